// File: wtc_pkg.sv
// Constants and types for the waveform timer control shell
package wtc_pkg;
  // Register byte offsets
  localparam logic [5:0] OFS_MAIN    = 6'h00;
  localparam logic [5:0] OFS_WAVE    = 6'h01;
  localparam logic [5:0] OFS_ROUTE   = 6'h02;
  localparam logic [5:0] OFS_OVRD    = 6'h03;
  localparam logic [5:0] OFS_CMD     = 6'h04;
  localparam logic [5:0] OFS_EVA     = 6'h08;
  localparam logic [5:0] OFS_EVB     = 6'h09;
  localparam logic [5:0] OFS_INTEN   = 6'h0c;
  localparam logic [5:0] OFS_INTFLAG = 6'h0d;
  localparam logic [5:0] OFS_STATE   = 6'h0e;
  localparam logic [5:0] OFS_INA     = 6'h10;
  localparam logic [5:0] OFS_INB     = 6'h11;
  localparam logic [5:0] OFS_FAULT   = 6'h12;
  localparam logic [5:0] OFS_DLYC    = 6'h14;
  localparam logic [5:0] OFS_DLYV    = 6'h15;
  localparam logic [5:0] OFS_DITC    = 6'h18;
  localparam logic [5:0] OFS_DITV    = 6'h19;
  localparam logic [5:0] OFS_DEBUG   = 6'h1e;
  localparam logic [5:0] OFS_CMPA_S  = 6'h28;
  localparam logic [5:0] OFS_CMPA_C  = 6'h2a;
  localparam logic [5:0] OFS_CMPB_S  = 6'h2c;
  localparam logic [5:0] OFS_CMPB_C  = 6'h2e;
  localparam logic [5:0] OFS_SHSTAT  = 6'h30;
  localparam logic [5:0] OFS_SHMASK  = 6'h31;
  // Field positions and masks
  localparam int         BIT_ENABLE  = 0;
  localparam logic [7:0] MAIN_FIELDS = 8'h7e;
  localparam logic [7:0] MASK_CMD    = 8'h9f;
  localparam logic [7:0] MASK_EV     = 8'hd5;
  localparam logic [7:0] MASK_INT    = 8'h0d;
  localparam logic [7:0] MASK_ROUTE  = 8'hcb;
  localparam logic [7:0] MASK_LOW2   = 8'h03;
  localparam logic [7:0] MASK_LOW4   = 8'h0f;
  localparam logic [7:0] MASK_DLYC   = 8'h3f;
  localparam logic [7:0] MASK_FULL   = 8'hff;
  localparam logic [7:0] MASK_NONE   = 8'h00;
  localparam logic [7:0] MASK_DEBUG  = 8'h05;
  localparam logic [7:0] MASK_SHELL  = 8'h07;
  localparam int         BIT_RUNHALT = 0;
  localparam int         BIT_HFAULT  = 2;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  // Sleep state codes from the power manager
  localparam logic [1:0] SLP_ACTIVE  = 2'h0;
  localparam logic [1:0] SLP_IDLE    = 2'h1;
  localparam logic [1:0] SLP_STANDBY = 2'h2;
  localparam logic [1:0] SLP_PWRDN   = 2'h3;
  // Divider terminal counts
  localparam logic [2:0] SDIV_LIM1   = 3'h0;
  localparam logic [2:0] SDIV_LIM2   = 3'h1;
  localparam logic [2:0] SDIV_LIM4   = 3'h3;
  localparam logic [2:0] SDIV_LIM8   = 3'h7;
  localparam logic [4:0] CDIV_LIM1   = 5'h00;
  localparam logic [4:0] CDIV_LIM4   = 5'h03;
  localparam logic [4:0] CDIV_LIM32  = 5'h1f;
  localparam logic [1:0] CDIV_RSVD   = 2'h3;
  // Unlock window, one instruction per cycle
  localparam logic [2:0] GUARD_WIN   = 3'h4;
  // Timer control bundle
  typedef struct packed {
    logic       run;
    logic [1:0] clk_src;
    logic [1:0] cnt_div;
    logic [1:0] sync_div;
  } wtc_timer_ctl_t;
endpackage

// File: wtc_shell.sv
// Control shell of the waveform timer: registers, sleep/debug gating, dividers
`timescale 1ns/10ps
`default_nettype none

module wtc_shell #(
  parameter int SYNC_LAT = 2
) (
  // Clock and reset
  input  wire  logic                   clock_i,
  input  wire  logic                   srst_i,
  // Register port
  input  wire  logic [5:0]             addr_i,
  input  wire  logic [7:0]             wdata_i,
  input  wire  logic                   wr_i,
  input  wire  logic                   rd_i,
  output logic       [7:0]             rdata_o,
  // System state
  input  wire  logic [1:0]             sleep_mode_i,
  input  wire  logic                   debug_halt_i,
  input  wire  logic                   unlock_key_i,
  input  wire  logic [2:0]             engine_flag_i,
  // Timer control
  output wtc_pkg::wtc_timer_ctl_t      ctrl_o,
  output logic       [7:0]             fault_ctrl_o,
  output logic                         fault_a_o,
  output logic                         fault_b_o,
  output logic                         sync_tick_o,
  output logic                         cnt_tick_o,
  output logic                         enable_sync_done_o,
  output logic                         irq_o
);

  // Crossing latency must fit the four-bit transfer counter
  if (SYNC_LAT < 1 || SYNC_LAT > 15) begin : g_lat_check
    $error("SYNC_LAT out of range");
  end

  localparam logic [3:0] SYNC_LAT_C = 4'(SYNC_LAT);

  logic [7:0] gen_r [0:63];
  logic [7:0] main_r;
  logic       en_sync_r;
  logic [3:0] sync_cnt_r;
  logic [7:0] dbg_r;
  logic [7:0] fault_r;
  logic [2:0] guard_cnt_r;
  logic [7:0] intflag_r;
  logic [2:0] shstat_r;
  logic [2:0] shmask_r;
  logic [7:0] rdata_r;
  logic [2:0] sdiv_cnt_r;
  logic [4:0] cdiv_cnt_r;
  logic       run_nxt;
  logic       wr_main;
  logic       en_done;
  logic       guard_open;
  logic       guard_reject;
  logic       halt_fault;
  logic       en_done_evt;
  logic [2:0] sdiv_lim;
  logic [4:0] cdiv_lim;

  // Write mask of each plain storage register; zero means not stored
  function automatic logic [7:0] plain_mask(input logic [5:0] a);
    case (a)
      wtc_pkg::OFS_WAVE:   plain_mask = wtc_pkg::MASK_LOW2;
      wtc_pkg::OFS_ROUTE:  plain_mask = wtc_pkg::MASK_ROUTE;
      wtc_pkg::OFS_OVRD:   plain_mask = wtc_pkg::MASK_FULL;
      wtc_pkg::OFS_CMD:    plain_mask = wtc_pkg::MASK_CMD;
      wtc_pkg::OFS_EVA,
      wtc_pkg::OFS_EVB:    plain_mask = wtc_pkg::MASK_EV;
      wtc_pkg::OFS_INTEN:  plain_mask = wtc_pkg::MASK_INT;
      wtc_pkg::OFS_INA,
      wtc_pkg::OFS_INB:    plain_mask = wtc_pkg::MASK_LOW4;
      wtc_pkg::OFS_DLYC:   plain_mask = wtc_pkg::MASK_DLYC;
      wtc_pkg::OFS_DLYV:   plain_mask = wtc_pkg::MASK_FULL;
      wtc_pkg::OFS_DITC:   plain_mask = wtc_pkg::MASK_LOW2;
      wtc_pkg::OFS_DITV:   plain_mask = wtc_pkg::MASK_LOW4;
      wtc_pkg::OFS_CMPA_S,
      wtc_pkg::OFS_CMPA_C,
      wtc_pkg::OFS_CMPB_S,
      wtc_pkg::OFS_CMPB_C: plain_mask = wtc_pkg::MASK_FULL;
      wtc_pkg::OFS_CMPA_S + 6'h01,
      wtc_pkg::OFS_CMPA_C + 6'h01,
      wtc_pkg::OFS_CMPB_S + 6'h01,
      wtc_pkg::OFS_CMPB_C + 6'h01: plain_mask = wtc_pkg::MASK_LOW4;
      default:             plain_mask = wtc_pkg::MASK_NONE;
    endcase
  endfunction

  // Decode and qualifiers
  assign wr_main      = wr_i && (addr_i == wtc_pkg::OFS_MAIN);
  assign en_done      = (sync_cnt_r == 4'h0);
  assign guard_open   = (guard_cnt_r != 3'h0);
  assign guard_reject = wr_i && (addr_i == wtc_pkg::OFS_FAULT) && !guard_open;
  assign halt_fault   = debug_halt_i && dbg_r[wtc_pkg::BIT_HFAULT];
  assign en_done_evt  = (sync_cnt_r == 4'h1);
  assign enable_sync_done_o = en_done;

  // Plain storage; captures and reserved bytes stay zero
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      for (int i = 0; i < 64; i++) begin
        gen_r[i] <= wtc_pkg::RST_BYTE;
      end
    end else if (wr_i && plain_mask(addr_i) != wtc_pkg::MASK_NONE) begin
      gen_r[addr_i] <= wdata_i & plain_mask(addr_i);
    end
  end

  // Main control: enable handshake and locked fields
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      main_r <= wtc_pkg::RST_BYTE;
    end else if (wr_main) begin
      if (en_done) begin
        main_r[wtc_pkg::BIT_ENABLE] <= wdata_i[wtc_pkg::BIT_ENABLE];
      end
      // Prescalers must not change under a running timer
      if (!main_r[wtc_pkg::BIT_ENABLE] && !en_sync_r) begin
        main_r[7:1] <= wdata_i[7:1] & wtc_pkg::MAIN_FIELDS[7:1];
      end
    end
  end

  // Enable transfer into the timer side, fixed latency
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sync_cnt_r <= 4'h0;
      en_sync_r  <= 1'b0;
    end else if (wr_main && en_done &&
                 wdata_i[wtc_pkg::BIT_ENABLE] != main_r[wtc_pkg::BIT_ENABLE]) begin
      sync_cnt_r <= SYNC_LAT_C;
    end else if (!en_done) begin
      sync_cnt_r <= sync_cnt_r - 4'h1;
      if (en_done_evt) begin
        en_sync_r <= main_r[wtc_pkg::BIT_ENABLE];
      end
    end
  end

  // Unlock window opened by the key write on the processor side
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      guard_cnt_r <= 3'h0;
    end else if (unlock_key_i) begin
      guard_cnt_r <= wtc_pkg::GUARD_WIN;
    end else if (guard_open) begin
      guard_cnt_r <= guard_cnt_r - 3'h1;
    end
  end

  // Fault output control, the only key-protected register
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      fault_r <= wtc_pkg::RST_BYTE;
    end else if (wr_i && addr_i == wtc_pkg::OFS_FAULT && guard_open) begin
      fault_r <= wdata_i;
    end
  end

  // Debug control, unprotected
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dbg_r <= wtc_pkg::RST_BYTE;
    end else if (wr_i && addr_i == wtc_pkg::OFS_DEBUG) begin
      dbg_r <= wdata_i & wtc_pkg::MASK_DEBUG;
    end
  end

  // Engine flags: sticky, write one to clear, set wins
  // Overflow lands in bit 0, trigger A in bit 2, trigger B in bit 3
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      intflag_r <= wtc_pkg::RST_BYTE;
    end else begin
      intflag_r <= (intflag_r & ~((wr_i && addr_i == wtc_pkg::OFS_INTFLAG) ?
                    wdata_i : wtc_pkg::MASK_NONE))
                 | ({4'h0, engine_flag_i[2:1], 1'b0, engine_flag_i[0]} & wtc_pkg::MASK_INT);
    end
  end

  // Shell events: enable done, rejected write, halt fault
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      shstat_r <= 3'h0;
    end else begin
      shstat_r <= (shstat_r & ~((wr_i && addr_i == wtc_pkg::OFS_SHSTAT) ?
                   wdata_i[2:0] : 3'h0))
                | {halt_fault, guard_reject, en_done_evt};
    end
  end

  // Shell event mask
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      shmask_r <= 3'h0;
    end else if (wr_i && addr_i == wtc_pkg::OFS_SHMASK) begin
      shmask_r <= wdata_i[2:0] & wtc_pkg::MASK_SHELL[2:0];
    end
  end

  // Level interrupt from either flag group
  assign irq_o = |(shstat_r & shmask_r) |
                 |(intflag_r & gen_r[wtc_pkg::OFS_INTEN]);

  // Read data in the cycle after the strobe only
  always_ff @(posedge clock_i) begin
    if (srst_i || !rd_i) begin
      rdata_r <= 8'h00;
    end else begin
      case (addr_i)
        wtc_pkg::OFS_MAIN:    rdata_r <= main_r;
        wtc_pkg::OFS_INTFLAG: rdata_r <= intflag_r;
        wtc_pkg::OFS_STATE:   rdata_r <= {6'h00, 1'b1, en_done};
        wtc_pkg::OFS_FAULT:   rdata_r <= fault_r;
        wtc_pkg::OFS_DEBUG:   rdata_r <= dbg_r;
        wtc_pkg::OFS_SHSTAT:  rdata_r <= {5'h00, shstat_r};
        wtc_pkg::OFS_SHMASK:  rdata_r <= {5'h00, shmask_r};
        default:              rdata_r <= gen_r[addr_i];
      endcase
    end
  end
  assign rdata_o = rdata_r;

  // Run decision from enable, sleep state and debug halt
  always_comb begin
    run_nxt = en_sync_r;
    if (sleep_mode_i == wtc_pkg::SLP_STANDBY || sleep_mode_i == wtc_pkg::SLP_PWRDN) begin
      run_nxt = 1'b0;
    end
    if (debug_halt_i && !dbg_r[wtc_pkg::BIT_RUNHALT]) begin
      run_nxt = 1'b0;
    end
  end

  // Registered control bundle and fault outputs
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl_o       <= '0;
      fault_a_o    <= 1'b0;
      fault_b_o    <= 1'b0;
      fault_ctrl_o <= 8'h00;
    end else begin
      ctrl_o.run      <= run_nxt;
      ctrl_o.clk_src  <= main_r[6:5];
      ctrl_o.cnt_div  <= main_r[4:3];
      ctrl_o.sync_div <= main_r[2:1];
      fault_a_o       <= halt_fault;
      fault_b_o       <= halt_fault;
      fault_ctrl_o    <= fault_r;
    end
  end

  // Divider terminal counts
  always_comb begin
    case (ctrl_o.sync_div)
      2'h0:    sdiv_lim = wtc_pkg::SDIV_LIM1;
      2'h1:    sdiv_lim = wtc_pkg::SDIV_LIM2;
      2'h2:    sdiv_lim = wtc_pkg::SDIV_LIM4;
      default: sdiv_lim = wtc_pkg::SDIV_LIM8;
    endcase
    case (ctrl_o.cnt_div)
      2'h0:    cdiv_lim = wtc_pkg::CDIV_LIM1;
      2'h1:    cdiv_lim = wtc_pkg::CDIV_LIM4;
      default: cdiv_lim = wtc_pkg::CDIV_LIM32;
    endcase
  end

  // Synchronizer divider; cleared while stopped so restart is clean
  always_ff @(posedge clock_i) begin
    if (srst_i || !ctrl_o.run) begin
      sdiv_cnt_r  <= 3'h0;
      sync_tick_o <= 1'b0;
    end else if (sdiv_cnt_r == sdiv_lim) begin
      sdiv_cnt_r  <= 3'h0;
      sync_tick_o <= 1'b1;
    end else begin
      sdiv_cnt_r  <= sdiv_cnt_r + 3'h1;
      sync_tick_o <= 1'b0;
    end
  end

  // Counter divider on synchronizer ticks; reserved code gives no ticks
  always_ff @(posedge clock_i) begin
    if (srst_i || !ctrl_o.run || ctrl_o.cnt_div == wtc_pkg::CDIV_RSVD) begin
      cdiv_cnt_r <= 5'h00;
      cnt_tick_o <= 1'b0;
    end else if (!sync_tick_o) begin
      cnt_tick_o <= 1'b0;
    end else if (cdiv_cnt_r == cdiv_lim) begin
      cdiv_cnt_r <= 5'h00;
      cnt_tick_o <= 1'b1;
    end else begin
      cdiv_cnt_r <= cdiv_cnt_r + 5'h01;
      cnt_tick_o <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  AST_SLEEP_STOP: assert property (
    (sleep_mode_i == wtc_pkg::SLP_STANDBY || sleep_mode_i == wtc_pkg::SLP_PWRDN)
    |=> !ctrl_o.run) else $error("timer runs in deep sleep");
  AST_IDLE_RUN: assert property (
    (sleep_mode_i == wtc_pkg::SLP_IDLE && en_sync_r && !debug_halt_i)
    |=> ctrl_o.run) else $error("timer stopped in idle");
  AST_HALT_FREEZE: assert property (
    (debug_halt_i && !dbg_r[wtc_pkg::BIT_RUNHALT]) |=> !ctrl_o.run)
    else $error("timer not frozen in halt");
  AST_RUN_HALTED: assert property (
    (debug_halt_i && dbg_r[wtc_pkg::BIT_RUNHALT] && en_sync_r &&
     sleep_mode_i == wtc_pkg::SLP_ACTIVE) |=> ctrl_o.run)
    else $error("timer frozen despite run-while-halted");
  AST_HALT_FAULT: assert property (
    (debug_halt_i && dbg_r[wtc_pkg::BIT_HFAULT]) |=> (fault_a_o && fault_b_o))
    else $error("halt fault missing");
  AST_GUARD_REJECT: assert property (
    guard_reject |=> (fault_r == $past(fault_r)))
    else $error("unguarded protected write taken");
  AST_GUARD_ACCEPT: assert property (
    (unlock_key_i ##1 (wr_i && addr_i == wtc_pkg::OFS_FAULT)) |=>
    (fault_r == $past(wdata_i))) else $error("guarded write lost");
  AST_DEBUG_OPEN: assert property (
    (wr_i && addr_i == wtc_pkg::OFS_DEBUG) |=>
    (dbg_r == ($past(wdata_i) & wtc_pkg::MASK_DEBUG)))
    else $error("debug control needs no key");
  AST_CLK_SEL: assert property (
    (wr_main && !main_r[wtc_pkg::BIT_ENABLE] && !en_sync_r) |=>
    ##1 (ctrl_o.clk_src == $past(wdata_i[6:5], 2)))
    else $error("clock source wrong");
  AST_CNT_DIV1: assert property (
    (ctrl_o.run && ctrl_o.cnt_div == 2'h0 && sync_tick_o) |=> cnt_tick_o)
    else $error("counter divide by one broken");
  AST_SYNC_DIV8: assert property (
    (sync_tick_o && ctrl_o.sync_div == 2'h3) |=> !sync_tick_o [*7])
    else $error("sync divide by eight broken");
  AST_EN_BUSY: assert property (
    (wr_main && !en_done) |=> (main_r[wtc_pkg::BIT_ENABLE] ==
    $past(main_r[wtc_pkg::BIT_ENABLE]))) else $error("enable changed while busy");
  AST_EN_XFER: assert property (
    (wr_main && en_done &&
     wdata_i[wtc_pkg::BIT_ENABLE] != main_r[wtc_pkg::BIT_ENABLE]) |=> !en_done ##[1:15]
    (en_done && en_sync_r == main_r[wtc_pkg::BIT_ENABLE]))
    else $error("enable transfer wrong");
  AST_FIELD_LOCK: assert property (
    (wr_main && en_sync_r) |=> (main_r[7:1] == $past(main_r[7:1])))
    else $error("locked field changed");

  COV_RUN_HALTED: cover property (debug_halt_i && dbg_r[wtc_pkg::BIT_RUNHALT] && ctrl_o.run);
  COV_GUARD_WRITE: cover property (unlock_key_i ##1 wr_i && addr_i == wtc_pkg::OFS_FAULT);
  COV_REJECT: cover property (guard_reject);
  COV_CNT32: cover property (cnt_tick_o && ctrl_o.cnt_div == 2'h2);

endmodule
`default_nettype wire

// File: wtc_host_model.sv
// Behavioural model of the processor side: unlock key, debug halt, sleep state
`timescale 1ns/10ps
`default_nettype none
module wtc_host_model (
  // Clock and reset
  input  wire  logic       clock_i,
  input  wire  logic       srst_i,
  // Requests from the bench
  input  wire  logic       key_req_i,
  input  wire  logic       halt_req_i,
  input  wire  logic [1:0] sleep_req_i,
  // Toward the shell
  output logic             unlock_key_o,
  output logic             debug_halt_o,
  output logic [1:0]       sleep_mode_o
);
  // Key store to the change guard, one instruction per cycle
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      unlock_key_o <= 1'b0;
    end else begin
      unlock_key_o <= key_req_i;
    end
  end
  // Halt and sleep levels leave the processor's own state flops
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      debug_halt_o <= 1'b0;
      sleep_mode_o <= 2'h0;
    end else begin
      debug_halt_o <= halt_req_i;
      sleep_mode_o <= sleep_req_i;
    end
  end
endmodule
`default_nettype wire

// File: waveform_timer_control_shell_tb_top.sv
// Self-checking bench for the waveform timer control shell
`timescale 1ns/10ps
`default_nettype none
module waveform_timer_control_shell_tb_top;
  localparam int LAT = 4;
  logic                    clock_i, srst_i, wr, rd, key_req, halt_req, ukey, halt;
  logic                    fault_a, fault_b, stick, ctick, done, irq;
  logic [5:0]              addr;
  logic [7:0]              wdata, rdata, fctl, d, v, r;
  logic [1:0]              sleep_req, sleep;
  logic [2:0]              eflag;
  wtc_pkg::wtc_timer_ctl_t ctrl;
  int                      n_errors, n_tests, seed, per, c;
  logic [5:0]              tofs [12];
  logic [7:0]              tmsk [12];

  wtc_host_model host (.clock_i(clock_i), .srst_i(srst_i), .key_req_i(key_req),
    .halt_req_i(halt_req), .sleep_req_i(sleep_req), .unlock_key_o(ukey),
    .debug_halt_o(halt), .sleep_mode_o(sleep));
  wtc_shell #(.SYNC_LAT(LAT)) dut (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sleep_mode_i(sleep),
    .debug_halt_i(halt), .unlock_key_i(ukey), .engine_flag_i(eflag), .ctrl_o(ctrl),
    .fault_ctrl_o(fctl), .fault_a_o(fault_a), .fault_b_o(fault_b), .sync_tick_o(stick),
    .cnt_tick_o(ctick), .enable_sync_done_o(done), .irq_o(irq));

  // 125 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One-cycle strobes; a gap cycle keeps a strobe from being set twice in one step
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] dat);
    @(posedge clock_i);
    addr  <= a;
    wdata <= dat;
    wr    <= 1'b1;
    @(posedge clock_i);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [5:0] a, output logic [7:0] dat);
    @(posedge clock_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock_i);
    rd   <= 1'b0;
    @(posedge clock_i);
    dat = rdata;
  endtask

  // Next enable change only once the transfer has landed
  task automatic wait_done;
    int i;
    repeat (2) @(posedge clock_i);
    for (i = 0; i < 100 && done !== 1'b1; i++) @(posedge clock_i);
    chk({7'h0, done}, 8'h01);
  endtask

  // Fields only change with the timer stopped
  task automatic cfg(input logic [7:0] val);
    wr_reg(wtc_pkg::OFS_MAIN, 8'h00);
    wait_done();
    wr_reg(wtc_pkg::OFS_MAIN, val & wtc_pkg::MAIN_FIELDS);
    wr_reg(wtc_pkg::OFS_MAIN, val | 8'h01);
    wait_done();
    repeat (3) @(posedge clock_i);
  endtask

  // Cycles between two successive ticks
  task automatic period(input bit cnt, output int n);
    int i;
    for (i = 0; i < 400 && (cnt ? ctick : stick) !== 1'b1; i++) @(posedge clock_i);
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while ((cnt ? ctick : stick) !== 1'b1 && n < 400);
  endtask

  task automatic send_key;
    @(posedge clock_i);
    key_req <= 1'b1;
    @(posedge clock_i);
    key_req <= 1'b0;
  endtask

  function automatic int cdiv(input int code);
    return (code == 0) ? 1 : (code == 1) ? 4 : 32;
  endfunction

  initial begin
    repeat (50000) @(posedge clock_i);
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    tofs = '{wtc_pkg::OFS_WAVE, wtc_pkg::OFS_ROUTE, wtc_pkg::OFS_OVRD, wtc_pkg::OFS_EVA,
             wtc_pkg::OFS_EVB, wtc_pkg::OFS_INA, wtc_pkg::OFS_INB, wtc_pkg::OFS_DLYC,
             wtc_pkg::OFS_DLYV, wtc_pkg::OFS_CMPA_S, 6'h22, 6'h05};
    tmsk = '{wtc_pkg::MASK_LOW2, wtc_pkg::MASK_ROUTE, wtc_pkg::MASK_FULL, wtc_pkg::MASK_EV,
             wtc_pkg::MASK_EV, wtc_pkg::MASK_LOW4, wtc_pkg::MASK_LOW4, wtc_pkg::MASK_DLYC,
             wtc_pkg::MASK_FULL, wtc_pkg::MASK_FULL, wtc_pkg::MASK_NONE, wtc_pkg::MASK_NONE};
    seed = 76;
    n_errors = 0;
    n_tests = 0;
    {wr, rd, key_req, halt_req, addr, wdata, sleep_req, eflag} = '0;
    srst_i = 1'b1;
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    // Reset state
    rd_reg(wtc_pkg::OFS_MAIN, d);
    chk(d, wtc_pkg::RST_BYTE);
    rd_reg(wtc_pkg::OFS_STATE, d);
    chk(d, 8'h03);
    // Random write and read back, read-only and unmapped places included
    for (c = 0; c < 12; c++) begin
      r = 8'($random(seed));
      wr_reg(tofs[c], r);
      rd_reg(tofs[c], d);
      chk(d, r & tmsk[c]);
    end
    // Every clock source, divider codes alongside, reserved counter code last
    for (c = 0; c < 4; c++) begin
      v = {1'b0, c[1:0], c[1:0], c[1:0], 1'b0};
      cfg(v);
      chk({1'b0, ctrl.clk_src, ctrl.cnt_div, ctrl.sync_div, ctrl.run}, v | 8'h01);
      period(1'b0, per);
      chk(per[7:0], 8'(1 << c));
      if (c < 3) begin
        period(1'b1, per);
        chk(per[7:0], 8'((1 << c) * cdiv(c)));
      end else begin
        per = 0;
        repeat (300) @(posedge clock_i) per += int'(ctick === 1'b1);
        chk(per[7:0], 8'h00);
      end
    end
    // Field writes while running are dropped
    r = 8'($random(seed)) & wtc_pkg::MAIN_FIELDS;
    wr_reg(wtc_pkg::OFS_MAIN, r | 8'h01);
    rd_reg(wtc_pkg::OFS_MAIN, d);
    chk(d, v | 8'h01);
    // Enable change while the transfer is still pending is dropped
    wr_reg(wtc_pkg::OFS_MAIN, v);
    @(posedge clock_i);
    chk({7'h0, done}, 8'h00);
    wr_reg(wtc_pkg::OFS_MAIN, v | 8'h01);
    wait_done();
    rd_reg(wtc_pkg::OFS_MAIN, d);
    chk(d, v);
    // Sleep states
    cfg(8'h00);
    for (c = 0; c < 4; c++) begin
      sleep_req <= c[1:0];
      repeat (4) @(posedge clock_i);
      chk({7'h0, ctrl.run}, (c < 2) ? 8'h01 : 8'h00);
    end
    sleep_req <= 2'h0;
    // Debug halt: freeze, run while halted, injected faults
    halt_req <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk({6'h0, ctrl.run, fault_a}, 8'h00);
    wr_reg(wtc_pkg::OFS_DEBUG, 8'h05);
    repeat (3) @(posedge clock_i);
    chk({6'h0, ctrl.run, 1'b1}, 8'h03);
    chk({6'h0, fault_a, fault_b}, 8'h03);
    halt_req <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk({6'h0, fault_a, fault_b}, 8'h00);
    wr_reg(wtc_pkg::OFS_DEBUG, 8'h00);
    // Protected register: no key, key inside window, key window run out
    r = 8'($random(seed)) | 8'h01;
    wr_reg(wtc_pkg::OFS_FAULT, r);
    rd_reg(wtc_pkg::OFS_FAULT, d);
    chk(d, 8'h00);
    // Key seen at edge N opens edges N+1 to N+4: first edge, last edge, one late
    send_key();
    wr_reg(wtc_pkg::OFS_FAULT, r);
    rd_reg(wtc_pkg::OFS_FAULT, d);
    chk(d, r);
    chk(fctl, r);
    send_key();
    repeat (3) @(posedge clock_i);
    wr_reg(wtc_pkg::OFS_FAULT, ~r);
    rd_reg(wtc_pkg::OFS_FAULT, d);
    chk(d, ~r);
    send_key();
    repeat (4) @(posedge clock_i);
    wr_reg(wtc_pkg::OFS_FAULT, r);
    rd_reg(wtc_pkg::OFS_FAULT, d);
    chk(d, ~r);
    // Shell status, mask and clear; timer flags with their enable
    wr_reg(wtc_pkg::OFS_SHMASK, 8'h02);
    @(posedge clock_i);
    chk({7'h0, irq}, 8'h01);
    rd_reg(wtc_pkg::OFS_SHSTAT, d);
    chk(d, 8'h07);
    wr_reg(wtc_pkg::OFS_SHSTAT, 8'h07);
    rd_reg(wtc_pkg::OFS_SHSTAT, d);
    chk({d[6:0], irq}, 8'h00);
    @(posedge clock_i);
    eflag <= 3'h7;
    @(posedge clock_i);
    eflag <= 3'h0;
    rd_reg(wtc_pkg::OFS_INTFLAG, d);
    chk({d[6:0], irq}, 8'h1a);
    wr_reg(wtc_pkg::OFS_INTEN, 8'h01);
    @(posedge clock_i);
    chk({7'h0, irq}, 8'h01);
    wr_reg(wtc_pkg::OFS_INTFLAG, 8'h01);
    @(posedge clock_i);
    chk({7'h0, irq}, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
